// ==== rcs_pkg.sv ====
/*
  Shared constants and types for the reader command interpreter: command codes,
  error codes, status byte layout, sequencing states.
  Assumes one 40 MHz clock and an active high asynchronous reset everywhere.
*/
package rcs_pkg;
  // Command codes on the link
  typedef enum logic [3:0] {
    RCS_CMD_PROG_WRITE = 4'h1,
    RCS_CMD_PROG_READ = 4'h2,
    RCS_CMD_MATCH_WRITE = 4'h3,
    RCS_CMD_MATCH_READ = 4'h4,
    RCS_CMD_LOCK_SET = 4'h5,
    RCS_CMD_LOCK_CLR = 4'h6,
    RCS_CMD_XCMP = 4'h7,
    RCS_CMD_DOUT = 4'h8,
    RCS_CMD_RESULT_READ = 4'h9,
    RCS_CMD_TRIG_READ = 4'hA,
    RCS_CMD_INIT = 4'hB,
    RCS_CMD_INIT_PROG = 4'hC
  } rcs_cmd_t;

  // Result codes, serial module path
  localparam logic [7:0] RCS_ERR_NONE = 8'h00;
  localparam logic [7:0] RCS_ERR_PRECOND = 8'h05;
  localparam logic [7:0] RCS_ERR_PARAM = 8'h0D;
  localparam logic [7:0] RCS_ERR_INITPROG = 8'h15;
  // Result codes, profile path (bytes 0..2)
  localparam logic [23:0] RCS_ST_PRECOND = 24'h01_FEE6;
  localparam logic [23:0] RCS_ST_PARAM = 24'h03_FEE1;
  localparam logic [23:0] RCS_ST_INITPROG = 24'h03_FEE6;
  localparam logic [23:0] RCS_ST_NONE = 24'h00_0000;

  localparam logic [15:0] RCS_WR_ADDR_OK = 16'h0000;
  localparam logic [7:0] RCS_PROG_MAX = 8'h0F;
  localparam logic [7:0] RCS_PROG_LEN_MAX = 8'h01;
  // Send area bytes 1..31, receive area bytes 1..4
  localparam logic [4:0] RCS_TX_FIRST = 5'h01;
  localparam logic [4:0] RCS_TX_LAST = 5'h1F;
  localparam logic [4:0] RCS_RX_LAST = 5'h04;

  // Status byte / control byte bit positions
  localparam int RCS_ST_INOP = 0;
  localparam int RCS_ST_RDY = 2;
  localparam int RCS_CTL_LOCK = 0;

  // Cycles the lockout is held while returning to run
  localparam logic [3:0] RCS_LOCK_HOLD = 4'h4;

  // Register offsets of the controller end (APB)
  localparam logic [7:0] RCS_REG_CMD = 8'h00;
  localparam logic [7:0] RCS_REG_ARG = 8'h04;
  localparam logic [7:0] RCS_REG_RES = 8'h08;
  localparam logic [7:0] RCS_REG_STAT = 8'h0C;

  typedef enum logic [1:0] {
    RCS_GE_NONE = 2'b00,
    RCS_GE_PRESENT = 2'b01,
    RCS_GE_IDENTIFIED = 2'b10,
    RCS_GE_RETURN = 2'b11
  } rcs_ge_t;
endpackage : rcs_pkg

// ==== rcs_if.sv ====
/*
  Link between controller end and reader end: one command strobe with its
  arguments, one answer strobe with result, live status byte.
  Assumes both ends share core_clk_in.
*/
`timescale 1ns/1ps
interface rcs_if;
  import rcs_pkg::*;
  logic cmd_valid;
  rcs_cmd_t cmd_code;
  logic [15:0] cmd_addr;
  logic [7:0] cmd_len;
  logic [7:0] cmd_data;
  logic profile_mode;
  logic rsp_valid;
  logic [7:0] rsp_err;
  logic [23:0] rsp_status;
  logic [7:0] rsp_data;
  logic [7:0] status_byte;
  logic status_valid;
  modport reader (input cmd_valid, cmd_code, cmd_addr, cmd_len, cmd_data, profile_mode,
    output rsp_valid, rsp_err, rsp_status, rsp_data, status_byte, status_valid);
  modport ctrl (output cmd_valid, cmd_code, cmd_addr, cmd_len, cmd_data, profile_mode,
    input rsp_valid, rsp_err, rsp_status, rsp_data, status_byte, status_valid);
endinterface : rcs_if

// ==== rcs_check.sv ====
/*
  Precondition and parameter checker for one command, purely combinational.
  Assumes inputs are stable registered state of the reader end.
*/
`timescale 1ns/1ps
module rcs_check
  import rcs_pkg::*;
(
  // Command
  input wire rcs_cmd_t code_in,
  input wire logic [15:0] addr_in,
  input wire logic [7:0] len_in,
  input wire logic [7:0] data_in,
  // Reader state
  input wire logic route_ok_in,
  input wire logic group_err_in,
  input wire logic run_in,
  input wire logic prog_stored_in,
  input wire logic self_test_in,
  // Verdict
  output logic precond_bad_out,
  output logic param_bad_out,
  output logic initprog_bad_out
);
  wire is_write = (code_in == RCS_CMD_PROG_WRITE) || (code_in == RCS_CMD_MATCH_WRITE) ||
    (code_in == RCS_CMD_LOCK_SET) || (code_in == RCS_CMD_LOCK_CLR) ||
    (code_in == RCS_CMD_XCMP) || (code_in == RCS_CMD_DOUT);
  wire need_ng = (code_in != RCS_CMD_DOUT) && (code_in != RCS_CMD_INIT) &&
    (code_in != RCS_CMD_INIT_PROG);
  wire need_run = (code_in == RCS_CMD_PROG_WRITE) || (code_in == RCS_CMD_MATCH_WRITE) ||
    (code_in == RCS_CMD_MATCH_READ) || (code_in == RCS_CMD_XCMP) ||
    (code_in == RCS_CMD_RESULT_READ) || (code_in == RCS_CMD_TRIG_READ);
  wire no_stop = need_run && (code_in != RCS_CMD_PROG_WRITE);
  // Program change allowed in run and stop alike
  wire mode_bad = (code_in == RCS_CMD_PROG_WRITE) ? 1'b0 : (no_stop && !run_in);
  // Init commands carry their own checks
  wire is_init = (code_in == RCS_CMD_INIT) || (code_in == RCS_CMD_INIT_PROG);

  assign precond_bad_out = !is_init && (!route_ok_in || (need_ng && group_err_in) || mode_bad);
  assign param_bad_out = !is_init && ((is_write && addr_in != RCS_WR_ADDR_OK) ||
    (code_in == RCS_CMD_PROG_WRITE && (len_in > RCS_PROG_LEN_MAX || data_in > RCS_PROG_MAX)));
  assign initprog_bad_out = (code_in == RCS_CMD_INIT_PROG) &&
    (data_in > RCS_PROG_MAX || !prog_stored_in || self_test_in);
endmodule : rcs_check

// ==== rcs_reader.sv ====
/*
  Reader end: takes commands from the link, checks them, answers with a
  result code, keeps program, lockout, run and group error state, and runs
  the identify-then-acknowledge group error sequence.
  Assumes one command outstanding at a time; fault events come from the
  image side as same-clock pulses.
*/
// Overview of operation
// - Answer each command with ready plus codes
// - Failed precondition answers 0x05 or E6 FE 01
// - Malformed command answers 0x0D or E1 FE 03
// - Write with nonzero address is bad parameter
// - Program write over one byte/above 15 rejected
// - Init with program fails if absent/self-test
// - Controller checks preconditions before sending commands (here it only refuses launches while busy)
// - Profile mode uses Ethernet path, not module
// - Some source must route to module path
// - Controller acknowledges group error before commanding
// - Group error: in-operation clear, status valid
// - First init reports the group error code
// - In-operation clear after init means group error
// - Second init acknowledges the group error
// - Acknowledge returns to run, lockout pulsed
// - Manually set lockout stays set afterwards
// - Acknowledge sets in-operation and run-ready bits
// - Acknowledging path must be controlling connection
// - Init with program also clears group error
// - Send area bytes 1 to 31 meaningful
// - Status bit0 in-operation, bit2 in run
// - Lockout bit blocks manual operator actions
`timescale 1ns/1ps
module rcs_reader
  import rcs_pkg::*;
(
  // Clock and reset
  input wire logic core_clk_in,
  input wire logic sys_rst_in,
  // Link
  rcs_if.reader link,
  // Connection settings
  input wire logic [3:0] module_route_in,
  input wire logic [3:0] eth_route_in,
  input wire logic ctrl_on_module_in,
  input wire logic ctrl_on_eth_in,
  // Image side
  input wire logic fault_in,
  input wire logic [7:0] fault_code_in,
  input wire logic self_test_in,
  input wire logic [15:0] prog_stored_in,
  input wire logic [7:0] result_in,
  // Operator panel
  input wire logic panel_start_in,
  input wire logic panel_ack_in,
  // State out
  output logic [3:0] prog_out,
  output logic operator_lockout_out,
  output logic panel_start_out,
  output logic panel_ack_out
);
  logic [3:0] prog_ff;
  logic lock_man_ff;
  logic lock_auto_ff;
  logic [3:0] hold_ff;
  logic run_ff;
  logic in_operation_flag_ff;
  logic [7:0] fault_code_ff;
  rcs_ge_t ge_ff;
  logic rsp_valid_ff;
  logic [7:0] rsp_err_ff;
  logic [23:0] rsp_status_ff;
  logic [7:0] rsp_data_ff;
  logic precond_bad;
  logic param_bad;
  logic initprog_bad;
  rcs_ge_t nxt_ge;

  // profile mode swaps module path for Ethernet path
  wire [3:0] route = link.profile_mode ? eth_route_in : module_route_in;
  wire ctrl_ok = link.profile_mode ? ctrl_on_eth_in : ctrl_on_module_in;
  // per-command source routing; digital out needs no source
  wire route_ok = (link.cmd_code == RCS_CMD_DOUT) ? 1'b1 :
    (link.cmd_code == RCS_CMD_RESULT_READ) ? route[2] :
    (link.cmd_code == RCS_CMD_TRIG_READ) ? (route[0] && route[2]) : route[3];
  // group error while status valid and not in operation
  wire group_err = !in_operation_flag_ff && link.status_valid;
  wire cmd = link.cmd_valid;
  wire is_init = cmd && link.cmd_code == RCS_CMD_INIT;
  wire is_initp = cmd && link.cmd_code == RCS_CMD_INIT_PROG;
  wire ok = cmd && !precond_bad && !param_bad && !initprog_bad;
  wire ack_ok = is_init && ctrl_ok && ge_ff == RCS_GE_IDENTIFIED;
  // init with program clears error too
  wire initp_ok = is_initp && !initprog_bad;
  wire returning = ack_ok || (initp_ok && ge_ff != RCS_GE_NONE);

  rcs_check u_check (
    .code_in(link.cmd_code),
    .addr_in(link.cmd_addr),
    .len_in(link.cmd_len),
    .data_in(link.cmd_data),
    .route_ok_in(route_ok),
    .group_err_in(group_err),
    .run_in(run_ff),
    .prog_stored_in(prog_stored_in[link.cmd_data[3:0]]),
    .self_test_in(self_test_in),
    .precond_bad_out(precond_bad),
    .param_bad_out(param_bad),
    .initprog_bad_out(initprog_bad)
  );

  // Group error sequence
  always_comb begin
    nxt_ge = ge_ff;
    case (ge_ff)
      RCS_GE_NONE: begin
        if (fault_in) begin
          nxt_ge = RCS_GE_PRESENT;
        end
      end
      RCS_GE_PRESENT: begin
        if (initp_ok) begin
          nxt_ge = RCS_GE_RETURN;
        end else if (is_init) begin
          nxt_ge = RCS_GE_IDENTIFIED;
        end
      end
      RCS_GE_IDENTIFIED: begin
        if (returning) begin
          nxt_ge = RCS_GE_RETURN;
        end
      end
      RCS_GE_RETURN: begin
        if (fault_in) begin
          nxt_ge = RCS_GE_PRESENT;
        end else if (hold_ff == 4'h0) begin
          nxt_ge = RCS_GE_NONE;
        end
      end
      default: nxt_ge = RCS_GE_NONE;
    endcase
  end

  always_ff @(posedge core_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      ge_ff <= RCS_GE_NONE;
      in_operation_flag_ff <= 1'b1;
      run_ff <= 1'b1;
      fault_code_ff <= RCS_ERR_NONE;
      lock_auto_ff <= 1'b0;
      hold_ff <= 4'h0;
    end else begin
      ge_ff <= nxt_ge;
      if (fault_in) begin
        in_operation_flag_ff <= 1'b0;
        run_ff <= 1'b0;
        fault_code_ff <= fault_code_in;
        lock_auto_ff <= 1'b0;
        hold_ff <= 4'h0;
      end else if (returning) begin
        // lockout forced during return to run
        lock_auto_ff <= 1'b1;
        hold_ff <= RCS_LOCK_HOLD;
      end else if (hold_ff != 4'h0) begin
        hold_ff <= hold_ff - 4'h1;
        if (hold_ff == 4'h1) begin
          in_operation_flag_ff <= 1'b1;
          run_ff <= 1'b1;
          lock_auto_ff <= 1'b0;
        end
      end
    end
  end

  // Program and manual lockout; only accepted commands change them
  always_ff @(posedge core_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      prog_ff <= 4'h0;
      lock_man_ff <= 1'b0;
    end else if (ok) begin
      if (link.cmd_code == RCS_CMD_PROG_WRITE || link.cmd_code == RCS_CMD_INIT_PROG) begin
        prog_ff <= link.cmd_data[3:0];
      end
      // manual lockout kept apart from automatic one
      if (link.cmd_code == RCS_CMD_LOCK_SET) begin
        lock_man_ff <= 1'b1;
      end else if (link.cmd_code == RCS_CMD_LOCK_CLR) begin
        lock_man_ff <= 1'b0;
      end
    end
  end

  // Answer, one cycle after the command
  always_ff @(posedge core_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      rsp_valid_ff <= 1'b0;
      rsp_err_ff <= RCS_ERR_NONE;
      rsp_status_ff <= RCS_ST_NONE;
      rsp_data_ff <= 8'h00;
    end else begin
      rsp_valid_ff <= cmd;
      if (cmd) begin
        rsp_data_ff <= 8'h00;
        if (initprog_bad) begin
          rsp_err_ff <= RCS_ERR_INITPROG;
          rsp_status_ff <= RCS_ST_INITPROG;
        end else if (precond_bad) begin
          rsp_err_ff <= RCS_ERR_PRECOND;
          rsp_status_ff <= RCS_ST_PRECOND;
        end else if (param_bad) begin
          rsp_err_ff <= RCS_ERR_PARAM;
          rsp_status_ff <= RCS_ST_PARAM;
        end else if (is_init && ge_ff == RCS_GE_PRESENT) begin
          rsp_err_ff <= fault_code_ff;
          rsp_status_ff <= {16'h0000, fault_code_ff};
        end else begin
          rsp_err_ff <= RCS_ERR_NONE;
          rsp_status_ff <= RCS_ST_NONE;
          if (link.cmd_code == RCS_CMD_PROG_READ) begin
            rsp_data_ff <= {4'h0, prog_ff};
          end else if (link.cmd_code == RCS_CMD_RESULT_READ ||
                       link.cmd_code == RCS_CMD_TRIG_READ) begin
            rsp_data_ff <= result_in;
          end
        end
      end
    end
  end

  wire lockout = lock_man_ff || lock_auto_ff;
  assign link.rsp_valid = rsp_valid_ff;
  assign link.rsp_err = rsp_err_ff;
  assign link.rsp_status = rsp_status_ff;
  assign link.rsp_data = rsp_data_ff;
  assign link.status_byte = {5'h00, run_ff, 1'b0, in_operation_flag_ff};
  assign link.status_valid = !self_test_in;
  assign prog_out = prog_ff;
  assign operator_lockout_out = lockout;
  assign panel_start_out = panel_start_in && !lockout;
  assign panel_ack_out = panel_ack_in && !lockout;
endmodule : rcs_reader

// ==== rcs_ctrl.sv ====
/*
  Controller end: APB slave registers hold a command and its arguments; a
  write to the command register launches it on the link unless busy, the result codes land
  in the result register and read data in the status register. Group error handling is left to software.
  Assumes the reader answers each command exactly once.
*/
`timescale 1ns/1ps
module rcs_ctrl
  import rcs_pkg::*;
(
  // Clock and reset
  input wire logic core_clk_in,
  input wire logic sys_rst_in,
  // APB
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [7:0] paddr_in,
  input wire logic [31:0] pwdata_in,
  output logic [31:0] prdata_out,
  output logic pready_out,
  output logic pslverr_out,
  // Link
  rcs_if.ctrl link
);
  logic busy_ff;
  logic go_ff;
  logic [3:0] code_ff;
  logic prof_ff;
  logic [31:0] arg_ff;
  logic [31:0] res_ff;
  logic [7:0] data_ff;
  logic done_ff;

  wire acc = psel_in && penable_in;
  wire wr = acc && pwrite_in;
  wire hit_cmd = paddr_in == RCS_REG_CMD;
  wire hit_arg = paddr_in == RCS_REG_ARG;
  wire hit_res = paddr_in == RCS_REG_RES;
  wire hit_stat = paddr_in == RCS_REG_STAT;
  wire mapped = hit_cmd || hit_arg || hit_res || hit_stat;
  // software checks status before launching; busy launches refused
  wire launch = wr && hit_cmd && !busy_ff;

  always_ff @(posedge core_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      busy_ff <= 1'b0;
      go_ff <= 1'b0;
      code_ff <= 4'h0;
      prof_ff <= 1'b0;
      arg_ff <= 32'h0000_0000;
      res_ff <= 32'h0000_0000;
      data_ff <= 8'h00;
      done_ff <= 1'b0;
    end else begin
      go_ff <= launch;
      if (launch) begin
        busy_ff <= 1'b1;
        done_ff <= 1'b0;
        code_ff <= pwdata_in[3:0];
        prof_ff <= pwdata_in[8];
      end else if (link.rsp_valid) begin
        busy_ff <= 1'b0;
        done_ff <= 1'b1;
        res_ff <= {link.rsp_status, link.rsp_err};
        data_ff <= link.rsp_data;
      end
      if (wr && hit_arg) begin
        arg_ff <= pwdata_in;
      end
    end
  end

  assign link.cmd_valid = go_ff;
  assign link.cmd_code = rcs_cmd_t'(code_ff);
  assign link.cmd_addr = arg_ff[15:0];
  assign link.cmd_len = arg_ff[23:16];
  assign link.cmd_data = arg_ff[31:24];
  assign link.profile_mode = prof_ff;

  assign pready_out = 1'b1;
  assign pslverr_out = acc && !mapped;
  assign prdata_out = hit_cmd ? {23'h0, prof_ff, 4'h0, code_ff} :
    hit_arg ? arg_ff :
    hit_res ? res_ff :
    hit_stat ? {14'h0, link.status_valid && !link.status_byte[RCS_ST_INOP], done_ff, data_ff,
      busy_ff, link.status_valid, link.status_byte[5:0]} : 32'h0000_0000;
endmodule : rcs_ctrl

// ==== rcs_asserts.sv ====
/*
  Checker on the link between the controller end and the reader end.
  Assumes the bench instantiates it beside the link, on the same clock.
*/
`timescale 1ns/1ps
module rcs_asserts
  import rcs_pkg::*;
(
  // Clock and reset
  input wire logic core_clk_in,
  input wire logic sys_rst_in,
  // Link
  input wire logic cmd_valid,
  input wire rcs_cmd_t cmd_code,
  input wire logic [15:0] cmd_addr,
  input wire logic [7:0] cmd_len,
  input wire logic [7:0] cmd_data,
  input wire logic profile_mode,
  input wire logic rsp_valid,
  input wire logic [7:0] rsp_err,
  input wire logic [23:0] rsp_status,
  input wire logic [7:0] status_byte,
  input wire logic status_valid
);
  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (sys_rst_in);
  logic grp_err;
  logic wr_cmd;
  assign grp_err = status_valid && !status_byte[RCS_ST_INOP];
  assign wr_cmd = cmd_code == RCS_CMD_PROG_WRITE || cmd_code == RCS_CMD_MATCH_WRITE;
  sequence s_cmd(c);
    cmd_valid && cmd_code == c;
  endsequence
  property p_rsp_follows; cmd_valid |=> rsp_valid; endproperty
  a_rsp_follows: assert property (p_rsp_follows) else $error("command not answered");
  property p_rsp_caused; rsp_valid |-> $past(cmd_valid); endproperty
  a_rsp_caused: assert property (p_rsp_caused) else $error("answer without command");
  property p_one_pulse; cmd_valid |=> !cmd_valid; endproperty
  a_one_pulse: assert property (p_one_pulse) else $error("command strobe too long");
  property p_group_rejects;
    s_cmd(RCS_CMD_PROG_WRITE) ##0 grp_err |=>
      (profile_mode ? rsp_status == RCS_ST_PRECOND : rsp_err == RCS_ERR_PRECOND);
  endproperty
  a_group_rejects: assert property (p_group_rejects) else $error("group fault ignored");
  property p_write_addr;
    cmd_valid && wr_cmd && !profile_mode && cmd_addr != RCS_WR_ADDR_OK |=> rsp_err != RCS_ERR_NONE;
  endproperty
  a_write_addr: assert property (p_write_addr) else $error("bad address accepted");
  property p_prog_param;
    s_cmd(RCS_CMD_PROG_WRITE) ##0 !profile_mode && (cmd_len > RCS_PROG_LEN_MAX ||
      cmd_data > RCS_PROG_MAX) |=> rsp_err != RCS_ERR_NONE;
  endproperty
  a_prog_param: assert property (p_prog_param) else $error("bad program accepted");
  property p_selftest;
    s_cmd(RCS_CMD_INIT_PROG) ##0 !status_valid |=>
      (profile_mode ? rsp_status == RCS_ST_INITPROG : rsp_err == RCS_ERR_INITPROG);
  endproperty
  a_selftest: assert property (p_selftest) else $error("init during self test");
  property p_run_with_inop; $rose(status_byte[RCS_ST_INOP]) |-> status_byte[RCS_ST_RDY]; endproperty
  a_run_with_inop: assert property (p_run_with_inop) else $error("run bit missing");
endmodule : rcs_asserts

// ==== reader_command_status_and_group_error_tb.sv ====
/*
  Bench for the reader command interpreter: both ends on one link, APB on
  the controller end, image and panel inputs on the reader end.
  Assumes package, link, both ends and checker are compiled first.
*/
`timescale 1ns/1ps
module reader_command_status_and_group_error_tb;
  import rcs_pkg::*;
  localparam logic [31:0] m_ser = 32'h0000_00ff;
  localparam logic [31:0] m_prof = 32'hffff_ff00;
  logic core_clk_in, sys_rst_in, psel, penable, pwrite, pready, pslverr, slv;
  logic fault, self_test, p_start, p_ack, lock, start_out, ack_out, ctl_mod, ctl_eth;
  logic [7:0] paddr, fcode, res_in, p;
  logic [31:0] pwdata, prdata, rd;
  logic [3:0] mod_route, eth_route, prog;
  logic [15:0] stored;
  logic [31:0] bad [5] = '{32'h0301_0001, 32'h0302_0000, 32'h1701_0000, 32'h0301_0004,
    32'h0301_0002};
  int err_total = 0, checked = 0, cyc = 0, lock_cnt = 0, c0;
  logic [31:0] exp_q [$], msk_q [$];
  rcs_if link();
  rcs_ctrl i_rcs_ctrl (.core_clk_in(core_clk_in), .sys_rst_in(sys_rst_in), .psel_in(psel),
    .penable_in(penable), .pwrite_in(pwrite), .paddr_in(paddr), .pwdata_in(pwdata),
    .prdata_out(prdata), .pready_out(pready), .pslverr_out(pslverr), .link(link.ctrl));
  rcs_reader i_rcs_reader (.core_clk_in(core_clk_in), .sys_rst_in(sys_rst_in),
    .link(link.reader), .module_route_in(mod_route), .eth_route_in(eth_route),
    .ctrl_on_module_in(ctl_mod), .ctrl_on_eth_in(ctl_eth), .fault_in(fault),
    .fault_code_in(fcode), .self_test_in(self_test), .prog_stored_in(stored),
    .result_in(res_in), .panel_start_in(p_start), .panel_ack_in(p_ack), .prog_out(prog),
    .operator_lockout_out(lock), .panel_start_out(start_out), .panel_ack_out(ack_out));
  rcs_asserts i_rcs_asserts (.core_clk_in(core_clk_in), .sys_rst_in(sys_rst_in),
    .cmd_valid(link.cmd_valid), .cmd_code(link.cmd_code), .cmd_addr(link.cmd_addr),
    .cmd_len(link.cmd_len), .cmd_data(link.cmd_data), .profile_mode(link.profile_mode),
    .rsp_valid(link.rsp_valid), .rsp_err(link.rsp_err), .rsp_status(link.rsp_status),
    .status_byte(link.status_byte), .status_valid(link.status_valid));

  initial begin
    core_clk_in = 1'b0;
    forever #12.5 core_clk_in = ~core_clk_in;
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] want);
    checked++;
    if (seen !== want) begin
      err_total++;
      $display("[ERR] t=%0t seen=%h want=%h", $time, seen, want);
    end
  endtask : check

  task automatic final_report();
    $display("checked=%0d err_total=%0d", checked, err_total);
    if (err_total == 0 && checked > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : final_report

  // Hang guard, well above the few hundred cycles the tests need
  always @(posedge core_clk_in) begin
    cyc <= cyc + 1;
    lock_cnt <= lock_cnt + (lock === 1'b1);
    if (cyc == 8000) begin
      err_total++;
      final_report();
    end
  end

  // Scoreboard: oldest note against each answer on the link
  always @(posedge core_clk_in) begin
    if (link.rsp_valid === 1'b1) begin
      if (exp_q.size() == 0) begin
        check(32'h0000_0001, 32'h0000_0000);
      end else begin
        check({link.rsp_status, link.rsp_err} & msk_q.pop_front(), exp_q.pop_front());
      end
    end
  end

  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge core_clk_in);
    penable <= 1'b1;
    do @(posedge core_clk_in); while (pready !== 1'b1);
    rd = prdata;
    slv = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge core_clk_in);
  endtask : apb

  task automatic cmd(input rcs_cmd_t c, input logic [31:0] arg, input logic prof,
      input logic [31:0] want, input logic [31:0] msk);
    exp_q.push_back(want);
    msk_q.push_back(msk);
    apb(1'b1, RCS_REG_ARG, arg);
    apb(1'b1, RCS_REG_CMD, {23'h0, prof, 4'h0, c});
    // Poll busy, done and the scoreboard queue; the note gives no fixed answer time to rely on
    do apb(1'b0, RCS_REG_STAT, 32'h0); while (rd[7] !== 1'b0 || rd[16] !== 1'b1 ||
      exp_q.size() != 0);
    apb(1'b0, RCS_REG_RES, 32'h0);
    check(rd & msk, want);
  endtask : cmd

  // Identify then acknowledge one group fault
  task automatic group(input logic manual);
    fcode <= 8'h80 | 8'($urandom_range(127, 0));
    fault <= 1'b1;
    @(posedge core_clk_in);
    fault <= 1'b0;
    @(posedge core_clk_in);
    apb(1'b0, RCS_REG_STAT, 32'h0);
    check({30'h0, rd[17], rd[0]}, 32'h2);
    cmd(RCS_CMD_PROG_WRITE, 32'h0101_0000, 1'b0, {24'h0, RCS_ERR_PRECOND}, m_ser);
    cmd(RCS_CMD_INIT, 32'h0, 1'b0, {24'h0, fcode}, m_ser);
    apb(1'b0, RCS_REG_STAT, 32'h0);
    check({30'h0, rd[17], rd[0]}, 32'h2);
    ctl_mod <= 1'b0;
    cmd(RCS_CMD_INIT, 32'h0, 1'b0, 32'h0, m_ser);
    apb(1'b0, RCS_REG_STAT, 32'h0);
    check({31'h0, rd[0]}, 32'h0);
    ctl_mod <= 1'b1;
    c0 = lock_cnt;
    cmd(RCS_CMD_INIT, 32'h0, 1'b0, 32'h0, m_ser);
    do apb(1'b0, RCS_REG_STAT, 32'h0); while (rd[0] !== 1'b1);
    check({29'h0, rd[2], rd[0], lock}, {29'h0, 2'b11, manual});
    check({31'h0, lock_cnt != c0}, 32'h1);
    $display("test group fault done");
  endtask : group

  initial begin
    sys_rst_in = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    mod_route = 4'hf;
    eth_route = 4'hf;
    ctl_mod = 1'b1;
    ctl_eth = 1'b0;
    fault = 1'b0;
    fcode = 8'h00;
    self_test = 1'b0;
    stored = 16'hffff;
    p_start = 1'b1;
    p_ack = 1'b1;
    void'($urandom(80497));
    res_in = 8'($urandom);
    repeat (6) @(posedge core_clk_in);
    sys_rst_in <= 1'b0;
    @(posedge core_clk_in);
    apb(1'b0, RCS_REG_STAT, 32'h0);
    check({24'h0, rd[6], rd[2], rd[0], lock, prog}, {24'h0, 4'b1110, 4'h0});
    apb(1'b0, 8'h10, 32'h0);
    check({31'h0, slv}, 32'h1);
    $display("test reset done");
    p = 8'($urandom_range(15, 0));
    cmd(RCS_CMD_PROG_WRITE, {p, 24'h01_0000}, 1'b0, 32'h0, m_ser);
    check({28'h0, prog}, {24'h0, p});
    cmd(RCS_CMD_PROG_READ, 32'h0, 1'b0, 32'h0, m_ser);
    apb(1'b0, RCS_REG_STAT, 32'h0);
    check({24'h0, rd[15:8]}, {24'h0, p});
    cmd(RCS_CMD_RESULT_READ, 32'h0, 1'b0, 32'h0, m_ser);
    apb(1'b0, RCS_REG_STAT, 32'h0);
    check({24'h0, rd[15:8]}, {24'h0, res_in});
    for (int i = 0; i < 5; i++) begin
      cmd((i == 4) ? RCS_CMD_MATCH_WRITE : RCS_CMD_PROG_WRITE, bad[i], i == 3,
        (i == 3) ? {RCS_ST_PARAM, 8'h00} : {24'h0, RCS_ERR_PARAM},
        (i == 3) ? m_prof : m_ser);
      check({28'h0, prog}, {24'h0, p});
    end
    $display("test parameters done");
    mod_route <= 4'b0111;
    cmd(RCS_CMD_PROG_WRITE, 32'h0201_0000, 1'b0, {24'h0, RCS_ERR_PRECOND}, m_ser);
    cmd(RCS_CMD_DOUT, 32'h0, 1'b0, 32'h0, m_ser);
    cmd(RCS_CMD_PROG_WRITE, 32'h0201_0000, 1'b1, 32'h0, m_prof);
    eth_route <= 4'b0111;
    cmd(RCS_CMD_PROG_WRITE, 32'h0301_0000, 1'b1, {RCS_ST_PRECOND, 8'h00}, m_prof);
    check({28'h0, prog}, 32'h2);
    mod_route <= 4'hf;
    eth_route <= 4'hf;
    $display("test routes done");
    p = 8'($urandom_range(15, 0));
    stored <= ~(16'h0001 << p);
    cmd(RCS_CMD_INIT_PROG, {p, 24'h01_0000}, 1'b0, {24'h0, RCS_ERR_INITPROG}, m_ser);
    stored <= 16'hffff;
    self_test <= 1'b1;
    cmd(RCS_CMD_INIT_PROG, {p, 24'h01_0000}, 1'b1, {RCS_ST_INITPROG, 8'h00}, m_prof);
    self_test <= 1'b0;
    $display("test init checks done");
    sys_rst_in <= 1'b1;
    repeat (2) @(posedge core_clk_in);
    sys_rst_in <= 1'b0;
    @(posedge core_clk_in);
    check({27'h0, lock, prog}, 32'h0);
    cmd(RCS_CMD_LOCK_SET, 32'h0, 1'b0, 32'h0, m_ser);
    check({29'h0, lock, start_out, ack_out}, 32'h4);
    group(1'b1);
    cmd(RCS_CMD_LOCK_CLR, 32'h0, 1'b0, 32'h0, m_ser);
    check({29'h0, lock, start_out, ack_out}, 32'h3);
    group(1'b0);
    fault <= 1'b1;
    @(posedge core_clk_in);
    fault <= 1'b0;
    @(posedge core_clk_in);
    cmd(RCS_CMD_INIT_PROG, 32'h0301_0000, 1'b0, 32'h0, m_ser);
    do apb(1'b0, RCS_REG_STAT, 32'h0); while (rd[0] !== 1'b1);
    check({31'h0, rd[17]}, 32'h0);
    $display("test init clears fault done");
    final_report();
  end
endmodule : reader_command_status_and_group_error_tb
